// ==== dac_port_pkg.sv ====
package dac_port_pkg;
   // ***************************************************
   // frame geometry, buffer depth and reset code
   // ***************************************************
   localparam int FRAME_BITS = 24;
   localparam int CODE_W = 16;
   localparam int CTRL_W = FRAME_BITS - CODE_W;
   localparam int FIFO_DEPTH = 16;
   localparam logic [CODE_W-1:0] CODE_RESET = 16'h0000;
   localparam logic [4:0] BIT_CNT_LAST = 5'h17;
   localparam logic [4:0] BIT_CNT_ZERO = 5'h00;

   typedef struct packed {
      logic [CTRL_W-1:0] ctrl;
      logic [CODE_W-1:0] code;
   } frame_s;
endpackage

// ==== serial_dac_input_port.sv ====

// ***************************************************
// word buffer
// ***************************************************
module frame_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 16
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
      $error("frame_fifo depth must be a power of two, at least 2");
   end

   // storage has no reset: only slots holding an unread word are ever used
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [AW:0] count_r;
   logic push;
   logic pop;

   // the extra count bit tells a full buffer from an empty one
   assign in_ready = (count_r != (AW+1)'(DEPTH));
   assign out_valid = (count_r != '0);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem_r[rd_ptr_r];

   always_ff @(posedge core_clk) begin
      if (push) begin
         mem_r[wr_ptr_r] <= in_data;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= wr_ptr_r + AW'(1);
         end
         if (pop) begin
            rd_ptr_r <= rd_ptr_r + AW'(1);
         end
         count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// ***************************************************
// serial input port
// ***************************************************
module serial_dac_input_port
   import dac_port_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic sclk,
   input wire logic frame_b,
   input wire logic din,
   input wire logic update_ready,
   output logic [CODE_W-1:0] analog_output,
   output logic [CTRL_W-1:0] frame_ctrl,
   output logic update_pulse,
   output logic word_pending
);
   // ***************************************************
   // elaboration checks
   // ***************************************************
   if (DEPTH < 2) begin : g_depth_chk
      $error("serial_dac_input_port needs a buffer depth of at least 2");
   end
   if (int'(BIT_CNT_LAST) != FRAME_BITS - 1) begin : g_cnt_chk
      $error("bit counter end point must be one less than the frame length");
   end
   if (FRAME_BITS != CTRL_W + CODE_W) begin : g_split_chk
      $error("frame must split exactly into control and code fields");
   end

   localparam int CNT_W = $bits(BIT_CNT_LAST);

   // the end-of-frame decode is shared by the shifter and the capture stage,
   // so both agree on which edge closes the frame
   function automatic logic is_last_bit(input logic [CNT_W-1:0] cnt);
      return cnt == BIT_CNT_LAST;
   endfunction

   // ***************************************************
   // link domain, clocked by the falling serial clock
   // ***************************************************
   // strobe high clears the frame asynchronously, so a partial frame
   // cannot survive a stopped serial clock
   logic link_clr_b;
   logic [FRAME_BITS-1:0] shift_r;
   logic [CNT_W-1:0] bit_cnt_r;
   logic frame_done_r;
   frame_s hold_r;
   logic word_tgl_r;

   assign link_clr_b = rst_b && !frame_b;

   // edges after the 24th are ignored until the strobe clears the frame
   always_ff @(negedge sclk or negedge link_clr_b) begin
      if (!link_clr_b) begin
         shift_r <= '0;
         bit_cnt_r <= BIT_CNT_ZERO;
         frame_done_r <= 1'b0;
      end else if (!frame_done_r) begin
         shift_r <= {shift_r[FRAME_BITS-2:0], din};
         bit_cnt_r <= bit_cnt_r + CNT_W'(1);
         if (is_last_bit(bit_cnt_r)) begin
            frame_done_r <= 1'b1;
         end
      end
   end

   // hold and toggle live outside the strobe clear: an abort never touches them
   always_ff @(negedge sclk or negedge rst_b) begin
      if (!rst_b) begin
         hold_r <= '0;
         word_tgl_r <= 1'b0;
      end else if (!frame_b && !frame_done_r && is_last_bit(bit_cnt_r)) begin
         hold_r <= frame_s'({shift_r[FRAME_BITS-2:0], din});
         word_tgl_r <= !word_tgl_r;
      end
   end

   // ***************************************************
   // crossing into core_clk
   // ***************************************************
   // hold_r is stable for at least a full frame after the toggle, so the
   // word is sampled without its own synchroniser
   logic tgl_meta_r;
   logic tgl_sync_r;
   logic tgl_seen_r;
   logic pend_r;
   frame_s pend_word_r;
   logic fifo_in_ready;
   logic fifo_out_valid;
   frame_s fifo_out;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         tgl_meta_r <= 1'b0;
         tgl_sync_r <= 1'b0;
         tgl_seen_r <= 1'b0;
      end else begin
         tgl_meta_r <= word_tgl_r;
         tgl_sync_r <= tgl_meta_r;
         tgl_seen_r <= tgl_sync_r;
      end
   end

   // a full buffer stalls the word here; a further frame meanwhile overwrites it
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         pend_r <= 1'b0;
         pend_word_r <= '0;
      end else begin
         if (tgl_sync_r != tgl_seen_r) begin
            pend_r <= 1'b1;
            pend_word_r <= hold_r;
         end else if (fifo_in_ready) begin
            pend_r <= 1'b0;
         end
      end
   end

   frame_fifo #(
      .WIDTH(FRAME_BITS),
      .DEPTH(DEPTH)
   ) u_fifo (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .in_valid(pend_r),
      .in_ready(fifo_in_ready),
      .in_data(pend_word_r),
      .out_valid(fifo_out_valid),
      .out_ready(update_ready),
      .out_data(fifo_out)
   );

   assign word_pending = pend_r;

   // ***************************************************
   // converter register
   // ***************************************************
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         analog_output <= CODE_RESET;
         frame_ctrl <= '0;
         update_pulse <= 1'b0;
      end else begin
         update_pulse <= fifo_out_valid && update_ready;
         if (fifo_out_valid && update_ready) begin
            analog_output <= fifo_out.code;
            frame_ctrl <= fifo_out.ctrl;
         end
      end
   end
endmodule

// ==== dac_host_model.sv ====
// *****
// host serial master
// *****
module dac_host_model (
   output logic sclk,
   output logic frame_b,
   output logic din
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      sclk = 1'h1;
      frame_b = 1'h1;
      din = 1'h0;
   end
   // clock idles high and stands still between frames
   task automatic send(input logic [23:0] w, input int n);
      #1.3 frame_b = 1'h0;
      for (int i = 0; i < n; i++) begin
         din = (i < 24) ? w[23-i] : ~din;
         #40 sclk = 1'h0;
         #40 sclk = 1'h1;
      end
      #10 din = ~din;
      frame_b = 1'h1;
      #200;
   endtask
endmodule

// ==== serial_dac_input_port_chk.sv ====
// *****
// port checker
// *****
module serial_dac_input_port_chk
   import dac_port_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic frame_b,
   input wire logic update_ready,
   input wire logic [CODE_W-1:0] analog_output,
   input wire logic [CTRL_W-1:0] frame_ctrl,
   input wire logic update_pulse,
   input wire logic word_pending
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   sequence s_pend;
      word_pending && update_ready ##1 update_ready[*2];
   endsequence
   property p_drain;
      s_pend |-> ##[0:2] update_pulse;
   endproperty
   a_drain: assert property (p_drain) else $error("pending word not applied");
   property p_code;
      $changed(analog_output) |-> update_pulse;
   endproperty
   a_code: assert property (p_code) else $error("code moved without update");
   property p_ctrl;
      $changed(frame_ctrl) |-> update_pulse;
   endproperty
   a_ctrl: assert property (p_ctrl) else $error("ctrl moved without update");
   property p_cause;
      update_pulse |-> $past(update_ready);
   endproperty
   a_cause: assert property (p_cause) else $error("update while stalled");
   // a word captured before the strobe rose shows before the strobe has been high for eight edges
   property p_gate;
      frame_b[*8] |-> !$rose(word_pending);
   endproperty
   a_gate: assert property (p_gate) else $error("word outside a frame");
   // with the converter side ready, a pending word enters the buffer within two edges
   property p_pend_clear;
      word_pending && update_ready |-> ##[1:2] !word_pending;
   endproperty
   a_pend_clear: assert property (p_pend_clear) else $error("pending word not taken");
endmodule
bind serial_dac_input_port serial_dac_input_port_chk u_chk (.core_clk(core_clk), .rst_b(rst_b),
   .frame_b(frame_b), .update_ready(update_ready), .analog_output(analog_output),
   .frame_ctrl(frame_ctrl), .update_pulse(update_pulse), .word_pending(word_pending));

// ==== serial_dac_input_port_bench.sv ====
// *****
// bench
// *****
module serial_dac_input_port_bench;
   import dac_port_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 1'h0, rst_b = 1'h0, update_ready = 1'h0, stall = 1'h0, update_pulse, word_pending;
   wire sclk, frame_b, din;
   logic [CODE_W-1:0] analog_output;
   logic [CTRL_W-1:0] frame_ctrl;
   logic [31:0] seed = 32'hCB7F;
   logic [31:0] rv;
   logic [23:0] exp_q[$];
   int error_cnt = 0, cmp_count = 0, cyc = 0;
   initial forever #2.5 core_clk = ~core_clk;
   dac_host_model u_dac_host_model (.sclk(sclk), .frame_b(frame_b), .din(din));
   serial_dac_input_port #(.DEPTH(FIFO_DEPTH)) u_serial_dac_input_port (.core_clk(core_clk),
      .rst_b(rst_b), .sclk(sclk), .frame_b(frame_b), .din(din), .update_ready(update_ready),
      .analog_output(analog_output), .frame_ctrl(frame_ctrl), .update_pulse(update_pulse),
      .word_pending(word_pending));
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task chk(string nm, logic [23:0] e, logic [23:0] g);
      cmp_count++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch %s exp %h got %h", nm, e, g);
      end
   endtask
   task tally_and_finish;
      $display("compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // short frames are aborts, so no word is expected from them
   task frame(int n);
      logic [23:0] w;
      w = 24'(rnd());
      if (n >= 24) exp_q.push_back(w);
      u_dac_host_model.send(w, n);
   endtask
   always @(posedge core_clk) begin
      rv = rnd();
      update_ready <= !stall && rv[0];
   end
   always @(posedge core_clk) begin
      cyc++;
      if (cyc > 60000) begin
         error_cnt++;
         tally_and_finish;
      end
   end
   // outputs launched at a rising edge are compared at the falling edge
   always @(negedge core_clk) begin
      if (update_pulse && exp_q.size() == 0) chk("spurious", 24'h0, 24'h1);
      else if (update_pulse) chk("word", exp_q.pop_front(), {frame_ctrl, analog_output});
   end
   initial begin
      repeat (4) @(posedge core_clk);
      rst_b <= 1'h1;
      chk("reset", 24'h0, {frame_ctrl, analog_output});
      repeat (20) frame(24);
      frame(23);
      frame(1);
      frame(26);
      $display("test frames done");
      repeat (100) @(posedge core_clk);
      stall <= 1'h1;
      repeat (FIFO_DEPTH + 1) frame(24);
      chk("pending", 24'h1, {23'h0, word_pending});
      // a word arriving while the buffer is full replaces the pending one
      frame(24);
      exp_q.delete(FIFO_DEPTH);
      chk("overwrite", 24'h1, {23'h0, word_pending});
      stall <= 1'h0;
      repeat (200) @(posedge core_clk);
      chk("left", 24'h0, 24'(exp_q.size()));
      $display("test buffer done");
      tally_and_finish;
   end
endmodule
